// ===== core/touch_i2c_defs.svh
// constants for the touch panel two-wire port
// assumes inclusion by bare name from core files
`ifndef TOUCH_I2C_DEFS_SVH
`define TOUCH_I2C_DEFS_SVH
`define TI_ADDR_PRIMARY 7'h5D
`define TI_ADDR_ALTERNATE 7'h14
`define TI_CLK_HZ 100000000
`define TI_STD_RATE_HZ 100000
`define TI_FAST_RATE_HZ 400000
`define TI_HALF_STD (`TI_CLK_HZ / `TI_STD_RATE_HZ / 2)
`define TI_HALF_FAST (`TI_CLK_HZ / `TI_FAST_RATE_HZ / 2)
`endif

// ===== core/touch_i2c_if.sv
// wire-level carrier joining the bus master and the touch slave
// assumes open-drain lines with pull-ups; enables are low while driving
`default_nettype none
interface touch_i2c_if;
  logic scl_o_m;
  logic scl_oe_n_m;
  logic sda_o_m;
  logic sda_oe_n_m;
  logic sda_o_s;
  logic sda_oe_n_s;
  wire logic scl;
  wire logic sda;
  assign scl = ~scl_oe_n_m ? scl_o_m : 1'b1;
  assign sda = (~sda_oe_n_m & ~sda_o_m) | (~sda_oe_n_s & ~sda_o_s) ?
    1'b0 : 1'b1;
  modport master (output scl_o_m, output scl_oe_n_m, output sda_o_m,
    output sda_oe_n_m, input scl, input sda);
  modport slave (output sda_o_s, output sda_oe_n_s, input scl, input sda);
endinterface
`default_nettype wire

// ===== core/touch_i2c_master.sv
// two-wire bus master that reaches the touch slave's register space
// assumes one command at a time; lines are open drain via the carrier
`include "touch_i2c_defs.svh"
`default_nettype none
module touch_i2c_master #(
  parameter logic [6:0] TARGET = `TI_ADDR_PRIMARY,
  parameter int HALF_STD = `TI_HALF_STD,
  parameter int HALF_FAST = `TI_HALF_FAST
) (
  input wire logic clk_sys,
  input wire logic rst,
  touch_i2c_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire touch_i2c_pkg::cmd_t cmd,
  input wire logic fast,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_len,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack_err
);
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_BIT, M_STOP, M_RSTART
  } mstate_t;

  mstate_t st_r, st_nxt;
  logic [9:0] tick_r, tick_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [8:0] sh_r, sh_nxt;
  logic [2:0] byte_r, byte_nxt;
  logic [7:0] left_r, left_nxt;
  logic rd_r, rd_nxt, rdphase_r, rdphase_nxt;
  logic scl_r, scl_nxt, sda_r, sda_nxt;
  logic [7:0] rdat_r, rdat_nxt;
  logic rv_r, rv_nxt, dn_r, dn_nxt, ne_r, ne_nxt;
  logic [15:0] a_r, a_nxt;
  logic [7:0] w_r, w_nxt;
  logic [1:0] sda_s_r;
  logic tick_end;

  assign tick_end = tick_r == (fast ? 10'(HALF_FAST - 1) :
    10'(HALF_STD - 1));

  function automatic logic [8:0] frame(input logic [7:0] b);
    frame = {b, 1'b1};
  endfunction

  always_comb begin
    st_nxt = st_r;
    tick_nxt = tick_end ? 10'h000 : tick_r + 10'h001;
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    byte_nxt = byte_r;
    left_nxt = left_r;
    rd_nxt = rd_r;
    rdphase_nxt = rdphase_r;
    scl_nxt = scl_r;
    sda_nxt = sda_r;
    rdat_nxt = rdat_r;
    a_nxt = a_r;
    w_nxt = w_r;
    rv_nxt = 1'b0;
    dn_nxt = 1'b0;
    ne_nxt = 1'b0;
    case (st_r)
      M_IDLE: begin
        tick_nxt = 10'h000;
        scl_nxt = 1'b1;
        sda_nxt = 1'b1;
        if (cmd_valid) begin
          rd_nxt = (cmd == touch_i2c_pkg::CMD_READ);
          a_nxt = cmd_addr;
          w_nxt = cmd_wdata;
          left_nxt = cmd_len;
          rdphase_nxt = 1'b0;
          st_nxt = M_START;
        end
      end
      M_START, M_RSTART: if (tick_end) begin
        ph_nxt = ph_r + 2'h1;
        if (ph_r == 2'h0) begin
          scl_nxt = 1'b1;
          sda_nxt = 1'b1;
        end else if (ph_r == 2'h1) begin
          sda_nxt = 1'b0;
        end else begin
          scl_nxt = 1'b0;
          ph_nxt = 2'h0;
          bit_nxt = 4'h0;
          byte_nxt = 3'h0;
          sh_nxt = frame({TARGET, rdphase_r});
          sda_nxt = TARGET[6];
          st_nxt = M_BIT;
        end
      end
      M_BIT: if (tick_end) begin
        if (ph_r == 2'h0) begin
          scl_nxt = 1'b1;
          ph_nxt = 2'h1;
        end else begin
          scl_nxt = 1'b0;
          ph_nxt = 2'h0;
          sh_nxt = {sh_r[7:0], sda_s_r[1]};
          bit_nxt = bit_r + 4'h1;
          sda_nxt = sh_r[7];
          if (bit_r == 4'h8) begin
            bit_nxt = 4'h0;
            // saturates so long reads keep counting as data bytes
            byte_nxt = (byte_r == 3'h7) ? byte_r : byte_r + 3'h1;
            if (rdphase_r && byte_r != 3'h0) begin
              rdat_nxt = sh_r[7:0];
              rv_nxt = 1'b1;
              left_nxt = left_r - 8'h01;
            end
            if (!rdphase_r && sda_s_r[1]) begin
              ne_nxt = 1'b1;
              st_nxt = M_STOP;
              sda_nxt = 1'b0;
            end else if (rdphase_r) begin
              if (byte_r != 3'h0 && left_r == 8'h01) begin
                st_nxt = M_STOP;
                sda_nxt = 1'b0;
              end else begin
                sh_nxt = {8'hFF, left_r == 8'h02 && byte_r != 3'h0};
                if (byte_r == 3'h0) begin
                  sh_nxt = {8'hFF, left_r == 8'h01};
                end
                sda_nxt = 1'b1;
              end
            end else if (byte_r == 3'h0) begin
              sh_nxt = frame(a_r[15:8]);
              sda_nxt = a_r[15];
            end else if (byte_r == 3'h1) begin
              sh_nxt = frame(a_r[7:0]);
              sda_nxt = a_r[7];
            end else if (byte_r == 3'h2 && !rd_r) begin
              sh_nxt = frame(w_r);
              sda_nxt = w_r[7];
            end else begin
              st_nxt = rd_r ? M_RSTART : M_STOP;
              rdphase_nxt = rd_r;
              sda_nxt = rd_r ? 1'b1 : 1'b0;
            end
          end
        end
      end
      M_STOP: if (tick_end) begin
        ph_nxt = ph_r + 2'h1;
        if (ph_r == 2'h0) begin
          scl_nxt = 1'b1;
        end else begin
          sda_nxt = 1'b1;
          ph_nxt = 2'h0;
          dn_nxt = 1'b1;
          st_nxt = M_IDLE;
        end
      end
      default: begin
        st_nxt = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_s_r <= 2'h3;
      st_r <= M_IDLE;
      tick_r <= 10'h000;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 9'h1FF;
      byte_r <= 3'h0;
      left_r <= 8'h00;
      rd_r <= 1'b0;
      rdphase_r <= 1'b0;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      rdat_r <= 8'h00;
      a_r <= 16'h0000;
      w_r <= 8'h00;
      rv_r <= 1'b0;
      dn_r <= 1'b0;
      ne_r <= 1'b0;
    end else begin
      sda_s_r <= {sda_s_r[0], bus.sda};
      st_r <= st_nxt;
      tick_r <= tick_nxt;
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      byte_r <= byte_nxt;
      left_r <= left_nxt;
      rd_r <= rd_nxt;
      rdphase_r <= rdphase_nxt;
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
      rdat_r <= rdat_nxt;
      a_r <= a_nxt;
      w_r <= w_nxt;
      rv_r <= rv_nxt;
      dn_r <= dn_nxt;
      ne_r <= ne_nxt;
    end
  end

  assign bus.scl_o_m = 1'b0;
  assign bus.scl_oe_n_m = scl_r;
  assign bus.sda_o_m = 1'b0;
  assign bus.sda_oe_n_m = sda_r;
  assign cmd_ready = (st_r == M_IDLE);
  assign rd_data = rdat_r;
  assign rd_valid = rv_r;
  assign done = dn_r;
  assign nack_err = ne_r;
endmodule
`default_nettype wire

// ===== core/touch_i2c_pkg.sv
// types used by the master end of the touch panel two-wire port and by the bench
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package touch_i2c_pkg;
  typedef enum logic [1:0] {
    CMD_WRITE,
    CMD_READ
  } cmd_t;
endpackage
`default_nettype wire

// ===== core/touch_i2c_slave.sv
// two-wire slave port of the touch panel controller
// assumes pins from outside clk_sys; user side is a 16-bit register bus
// Function
// - answer at seven-bit address 0x5D
// - two selectable addresses, chosen at reset pin release
// - works at 100 kHz and 400 kHz
// - master alone starts transfers with start
// - master ends each transfer with stop
// - acknowledge matching address byte on ninth clock
// - mismatch: no acknowledge, idle until start
// - nine clocks per byte including acknowledge
// - write: address, pointer high, low, data
// - pointer increments after each written byte
// - read: set pointer, repeated start, read
// - sequential read while master acknowledges
// - master acks bytes, nacks last, then stops
`include "touch_i2c_defs.svh"
`default_nettype none
module touch_i2c_slave #(
  parameter logic [6:0] ADDR_A = `TI_ADDR_PRIMARY,
  parameter logic [6:0] ADDR_B = `TI_ADDR_ALTERNATE
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic addr_sel_alt,
  touch_i2c_if.slave bus,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic reg_re,
  input wire logic [7:0] reg_rdata
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR_H, ST_PTR_L, ST_WDATA, ST_RDATA
  } state_t;

  logic [1:0] scl_s_r, sda_s_r;
  logic scl_d_r, sda_d_r;
  logic alt_r, alt_nxt, taken_r, taken_nxt;
  state_t st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic drive_r, drive_nxt, ackph_r, ackph_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic we_r, we_nxt, re_r, re_nxt;
  logic scl_rise, scl_fall, start_c, stop_c;
  // reset pin and strap are asynchronous: two flops each before use
  logic rstn_q_r, sync_rst_n_r, alt_q_r, alt_s_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      rstn_q_r <= 1'b0;
      sync_rst_n_r <= 1'b0;
      alt_q_r <= 1'b0;
      alt_s_r <= 1'b0;
    end else begin
      scl_s_r <= {scl_s_r[0], bus.scl};
      sda_s_r <= {sda_s_r[0], bus.sda};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
      rstn_q_r <= reset_n;
      sync_rst_n_r <= rstn_q_r;
      alt_q_r <= addr_sel_alt;
      alt_s_r <= alt_q_r;
    end
  end

  // edge detection only after the two-flop stage; 100 MHz oversamples both
  assign scl_rise = scl_s_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_s_r[1] & scl_d_r;
  assign start_c = scl_s_r[1] & scl_d_r & ~sda_s_r[1] & sda_d_r;
  assign stop_c = scl_s_r[1] & scl_d_r & sda_s_r[1] & ~sda_d_r;

  function automatic logic addr_hit(input logic [6:0] a, input logic alt);
    addr_hit = (a == (alt ? ADDR_B : ADDR_A));
  endfunction

  always_comb begin
    alt_nxt = alt_r;
    taken_nxt = taken_r;
    // strap caught at first clocks after reset pin release
    if (!sync_rst_n_r) begin
      taken_nxt = 1'b0;
    end else if (!taken_r) begin
      alt_nxt = alt_s_r;
      taken_nxt = 1'b1;
    end
  end

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    drive_nxt = drive_r;
    ackph_nxt = ackph_r;
    wd_nxt = wd_r;
    we_nxt = 1'b0;
    re_nxt = 1'b0;
    if (!sync_rst_n_r) begin
      st_nxt = ST_IDLE;
      drive_nxt = 1'b0;
      bit_nxt = 4'h0;
      ackph_nxt = 1'b0;
    end else if (start_c) begin
      st_nxt = ST_ADDR;
      bit_nxt = 4'h0;
      drive_nxt = 1'b0;
      ackph_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt = ST_IDLE;
      drive_nxt = 1'b0;
    end else if (st_r != ST_IDLE) begin
      if (scl_rise && !ackph_r) begin
        // read bytes rotate so the bit to send next is always bit 7
        sh_nxt = (st_r == ST_RDATA) ? {sh_r[6:0], sh_r[7]} :
          {sh_r[6:0], sda_s_r[1]};
        bit_nxt = bit_r + 4'h1;
      end else if (scl_rise && ackph_r && st_r == ST_RDATA && !drive_r) begin
        if (sda_s_r[1]) begin
          st_nxt = ST_IDLE;
        end else begin
          re_nxt = 1'b1;
        end
      end else if (scl_fall) begin
        if (ackph_r) begin
          ackph_nxt = 1'b0;
          bit_nxt = 4'h0;
          drive_nxt = 1'b0;
          if (st_r == ST_RDATA) begin
            sh_nxt = reg_rdata;
            drive_nxt = ~reg_rdata[7];
            ptr_nxt = ptr_r + 16'h0001;
          end
        end else if (bit_r == 4'h8) begin
          ackph_nxt = 1'b1;
          drive_nxt = 1'b1;
          case (st_r)
            ST_ADDR: begin
              if (!addr_hit(sh_r[7:1], alt_r)) begin
                st_nxt = ST_IDLE;
                drive_nxt = 1'b0;
                ackph_nxt = 1'b0;
              end else if (sh_r[0]) begin
                st_nxt = ST_RDATA;
              end else begin
                st_nxt = ST_PTR_H;
              end
            end
            ST_PTR_H: begin
              ptr_nxt = {sh_r, ptr_r[7:0]};
              st_nxt = ST_PTR_L;
            end
            ST_PTR_L: begin
              ptr_nxt = {ptr_r[15:8], sh_r};
              st_nxt = ST_WDATA;
            end
            ST_WDATA: begin
              wd_nxt = sh_r;
              we_nxt = 1'b1;
            end
            ST_RDATA: begin
              drive_nxt = 1'b0; // master answers here
            end
            default: begin
              st_nxt = ST_IDLE;
            end
          endcase
        end else if (st_r == ST_RDATA) begin
          drive_nxt = ~sh_r[7];
        end
      end
    end
    if (we_r) begin
      ptr_nxt = ptr_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alt_r <= 1'b0;
      taken_r <= 1'b0;
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 16'h0000;
      drive_r <= 1'b0;
      ackph_r <= 1'b0;
      wd_r <= 8'h00;
      we_r <= 1'b0;
      re_r <= 1'b0;
    end else begin
      alt_r <= alt_nxt;
      taken_r <= taken_nxt;
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      drive_r <= drive_nxt;
      ackph_r <= ackph_nxt;
      wd_r <= wd_nxt;
      we_r <= we_nxt;
      re_r <= re_nxt;
    end
  end

  // open drain: only ever pulls low
  assign bus.sda_o_s = 1'b0;
  assign bus.sda_oe_n_s = ~drive_r;
  assign reg_addr = ptr_r;
  assign reg_wdata = wd_r;
  assign reg_we = we_r;
  assign reg_re = re_r;
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// bench: master and touch slave joined by the carrier, random traffic
// assumes core files compile first; half periods shortened for speed
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 100000;
  logic clk_sys, rst, reset_n, addr_sel_alt, cmd_valid, cmd_ready, fast;
  touch_i2c_pkg::cmd_t cmd;
  logic [15:0] cmd_addr, reg_addr;
  logic [7:0] cmd_wdata, cmd_len, rd_data, reg_wdata, reg_rdata;
  logic rd_valid, done, nack_err, reg_we, reg_re;
  logic [7:0] mem [256];
  logic [7:0] shadow [256];
  logic [31:0] seed = 32'h00013C15;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  touch_i2c_if bus_if ();
  touch_i2c_slave touch_i2c_slave_inst (
    .clk_sys(clk_sys), .rst(rst), .reset_n(reset_n),
    .addr_sel_alt(addr_sel_alt), .bus(bus_if), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata));
  touch_i2c_master #(.HALF_STD(20), .HALF_FAST(10)) touch_i2c_master_inst (
    .clk_sys(clk_sys), .rst(rst), .bus(bus_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .fast(fast), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .rd_data(rd_data),
    .rd_valid(rd_valid), .done(done), .nack_err(nack_err));
  touch_i2c_assertions touch_i2c_assertions_inst (
    .clk_sys(clk_sys), .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
    .scl_oe_n_m(bus_if.scl_oe_n_m), .sda_oe_n_s(bus_if.sda_oe_n_s));
  // register space seen through the low pointer byte only
  assign reg_rdata = mem[reg_addr[7:0]];
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (reg_we === 1'b1) begin
      mem[reg_addr[7:0]] <= reg_wdata;
    end
    if (cyc == LIMIT) begin
      failures++;
      conclude();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("ERROR %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic run(input touch_i2c_pkg::cmd_t c, input logic f,
      input logic [15:0] a, input logic [7:0] d, input logic [7:0] n,
      input logic en);
    int k;
    int w;
    int r;
    logic ne;
    k = 0;
    w = 0;
    r = 0;
    ne = 1'b0;
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= c;
    fast <= f;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_len <= n;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clk_sys);
      if (nack_err === 1'b1) ne = 1'b1;
      if (reg_re === 1'b1) r++;
      if (reg_we === 1'b1) begin
        w++;
        check(reg_addr, a);
        check({8'h00, reg_wdata}, {8'h00, d});
      end
      if (rd_valid === 1'b1) begin
        check({8'h00, rd_data}, {8'h00, shadow[8'(a + k)]});
        k++;
      end
    end while (done !== 1'b1);
    check({15'h0000, ne}, {15'h0000, en});
    if (c == touch_i2c_pkg::CMD_READ) begin
      check(16'(k), {8'h00, n});
      check(16'(r), {8'h00, n - 8'h01});
    end else begin
      check(16'(w), {15'h0000, !en});
      if (!en) begin
        shadow[a[7:0]] = d;
        check(reg_addr, a + 16'h0001);
      end
    end
    $display("%0t test done cmd %0d nack %0d", $time, c, ne);
  endtask
  initial begin
    logic [15:0] a;
    logic [7:0] d;
    rst = 1'b1;
    reset_n = 1'b1;
    addr_sel_alt = 1'b0;
    cmd_valid = 1'b0;
    cmd = touch_i2c_pkg::CMD_WRITE;
    fast = 1'b0;
    cmd_addr = 16'h0000;
    cmd_wdata = 8'h00;
    cmd_len = 8'h01;
    for (int j = 0; j < 256; j++) begin
      mem[j] = 8'(j) ^ 8'hA5;
      shadow[j] = 8'(j) ^ 8'hA5;
    end
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    // rates alternate; pointer wrap and zero data as corners
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 16'hFFFF : 16'(rnd());
      d = (i == 1) ? 8'h00 : 8'(rnd());
      run(touch_i2c_pkg::CMD_WRITE, 1'(i), a, d, 8'h01, 1'b0);
      run(touch_i2c_pkg::CMD_READ, 1'(i), a, 8'h00, 8'(i % 4 + 1), 1'b0);
    end
    @(posedge clk_sys);
    reset_n <= 1'b0;
    run(touch_i2c_pkg::CMD_WRITE, 1'b1, 16'h0010, 8'h3C, 8'h01, 1'b1);
    @(posedge clk_sys);
    addr_sel_alt <= 1'b1;
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    run(touch_i2c_pkg::CMD_WRITE, 1'b0, 16'h0011, 8'h4B, 8'h01, 1'b1);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    addr_sel_alt <= 1'b0;
    @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    run(touch_i2c_pkg::CMD_READ, 1'b0, 16'h0010, 8'h00, 8'h02, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire

// ===== testbench/touch_i2c_assertions.sv
// wire-level checks on the carrier between master and touch slave
// assumes one clk_sys domain; tb instantiates it beside the carrier
`default_nettype none
module touch_i2c_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_n_m,
  input wire logic sda_oe_n_s
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SPAN = 100;
  logic scl_q_r;
  logic sda_q_r;
  logic drove_r;
  logic drove_nxt;
  logic [3:0] rises_r;
  logic [3:0] rises_nxt;
  // rises since the last start; saturates so a long read cannot wrap
  always_comb begin
    rises_nxt = rises_r;
    drove_nxt = drove_r;
    if (scl && scl_q_r && sda_q_r && !sda) begin
      rises_nxt = 4'h0;
      drove_nxt = 1'b0;
    end else if (scl && !scl_q_r && rises_r != 4'hF) begin
      rises_nxt = rises_r + 4'h1;
    end
    if (!sda_oe_n_s) begin
      drove_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      drove_r <= 1'b0;
      rises_r <= 4'h0;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      drove_r <= drove_nxt;
      rises_r <= rises_nxt;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  AST_RST_RELEASED:
    assert property (disable iff (1'b0) rst |-> sda_oe_n_s && scl_oe_n_m)
    else $error("line held during reset");
  AST_START_THEN_CLOCK:
    assert property (s_start |-> ##[1:SPAN] !scl)
    else $error("no clock after start");
  AST_STOP_SLAVE_QUIET:
    assert property (s_stop |-> sda_oe_n_s)
    else $error("slave drives at stop");
  AST_IDLE_AFTER_STOP:
    assert property (s_stop |-> scl_oe_n_m [*8])
    else $error("clock pulled right after stop");
  AST_SLAVE_MOVES_LOW:
    assert property ($changed(sda_oe_n_s) |-> !scl)
    else $error("slave data moved with clock high");
  AST_SLAVE_HOLDS_HIGH:
    assert property ($rose(scl) && !sda_oe_n_s |-> !sda_oe_n_s [*8])
    else $error("slave bit dropped in clock high");
  AST_FIRST_ACK_NINTH:
    assert property ($fell(sda_oe_n_s) && !drove_r |-> rises_r == 4'h8)
    else $error("address ack not on ninth clock");
  AST_LOW_BOUNDED:
    assert property ($fell(scl) |-> ##[1:SPAN] scl)
    else $error("clock low too long");
endmodule
`default_nettype wire
